//--- pio_ports.sv
// Three parallel ports: high-current port 0, direction-controlled port 1, shared port 2.
//
// Contract
// - Output values live in latches; pins are read unlatched at read time.
// - A port read samples the pin levels in its first state.
// - A port write changes pin outputs in its second state.
// - Reset sets port 0 latch to ones and drive select to zero.
// - Port 0 drive select picks open-drain or push-pull per bit.
// - Port 0 data read gives latch; pin-read register gives pin levels.
// - Serial mode uses port 0 bits 2/3; normal mode bits 1/0 for UART.
// - Port 1 has direction register; reset clears direction and latch.
// - Port 1 direction 0 is input, 1 drives the latch value.
// - Port 1 bit 1 always feeds its interrupt, even as output.
// - Port 1 bit 0 is general I/O or interrupt input by select bit.
// - Port 2 latch resets to ones.
// - Dual-clock mode gives port 2 bits 1 and 2 to the resonator.
// - Port 2 latch and pin reads; bits 7 to 3 are indeterminate.
// - Port 2 bit 0 falling edge sets its interrupt even as output.
// - In stop mode port 2 bit 0 is released regardless of enable.
// - Select 0 means port 1 bit 0 I/O, 1 means interrupt input.
`default_nettype none
module pio_ports
  import pio_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Internal register bus.
  input wire logic [15:0] busAddr,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic [7:0] busWdata,
  output logic [7:0] busRdata,
  output logic busRdataValid,
  // Mode and function controls.
  input wire logic serialProgMode,
  input wire logic dualClockMode,
  input wire logic stopMode,
  input wire logic pin10InterruptSelect,
  input wire logic uartTxd,
  // Port 0 pins.
  input wire logic [pio_pkg::PIO_P0_W-1:0] port0PinIn,
  output logic [pio_pkg::PIO_P0_W-1:0] port0PinOut,
  output logic [pio_pkg::PIO_P0_W-1:0] port0PinOe,
  // Port 1 pins.
  input wire logic [pio_pkg::PIO_P1_W-1:0] port1PinIn,
  output logic [pio_pkg::PIO_P1_W-1:0] port1PinOut,
  output logic [pio_pkg::PIO_P1_W-1:0] port1PinOe,
  // Port 2 pins.
  input wire logic [pio_pkg::PIO_P2_W-1:0] port2PinIn,
  output logic [pio_pkg::PIO_P2_W-1:0] port2PinOut,
  output logic [pio_pkg::PIO_P2_W-1:0] port2PinOe,
  // Function inputs and interrupt edge pulses.
  output logic uartRxd,
  output logic int0Fall,
  output logic int1Rise,
  output logic int1Fall,
  output logic stopFall
);
  import pio_pkg::*;

  // Pending write stage: taken in the first state, applied in the second.
  logic wrPend_reg, wrPend_next;
  logic [15:0] wrAddr_reg, wrAddr_next;
  logic [7:0] wrData_reg, wrData_next;
  // Port registers.
  logic [7:0] p0Latch_reg, p0Latch_next;
  logic [7:0] p0Drive_reg, p0Drive_next;
  logic [6:0] p1Latch_reg, p1Latch_next;
  logic [6:0] p1Dir_reg, p1Dir_next;
  logic [2:0] p2Latch_reg, p2Latch_next;
  // Registered pin drive.
  logic [7:0] p0Out_reg, p0Out_next, p0Oe_reg, p0Oe_next;
  logic [6:0] p1Out_reg, p1Out_next, p1Oe_reg, p1Oe_next;
  logic [2:0] p2Out_reg, p2Out_next, p2Oe_reg, p2Oe_next;
  logic rxd_reg, rxd_next;
  // Read answer.
  logic [7:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic [2:0] edgeRise, edgeFall;

  always_comb begin
    wrPend_next = busWrite;
    wrAddr_next = busWrite ? busAddr : wrAddr_reg;
    wrData_next = busWrite ? busWdata : wrData_reg;
    p0Latch_next = p0Latch_reg;
    p0Drive_next = p0Drive_reg;
    p1Latch_next = p1Latch_reg;
    p1Dir_next = p1Dir_reg;
    p2Latch_next = p2Latch_reg;
    if (wrPend_reg) begin
      unique case (wrAddr_reg)
        PIO_OFF_P0_LATCH: p0Latch_next = wrData_reg;
        PIO_OFF_P0_DRIVE: p0Drive_next = wrData_reg;
        PIO_OFF_P1_LATCH: p1Latch_next = wrData_reg[6:0];
        PIO_OFF_P1_DIR: p1Dir_next = wrData_reg[6:0];
        PIO_OFF_P2_LATCH: p2Latch_next = wrData_reg[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 16'h0000;
      wrData_reg <= 8'h00;
      p0Latch_reg <= PIO_P0_LATCH_RST;
      p0Drive_reg <= PIO_P0_DRIVE_RST;
      p1Latch_reg <= PIO_P1_LATCH_RST;
      p1Dir_reg <= PIO_P1_DIR_RST;
      p2Latch_reg <= PIO_P2_LATCH_RST;
    end else begin
      wrPend_reg <= wrPend_next;
      wrAddr_reg <= wrAddr_next;
      wrData_reg <= wrData_next;
      p0Latch_reg <= p0Latch_next;
      p0Drive_reg <= p0Drive_next;
      p1Latch_reg <= p1Latch_next;
      p1Dir_reg <= p1Dir_next;
      p2Latch_reg <= p2Latch_next;
    end
  end

  // Pin drive is computed from the next latch values so that the pins move in the same
  // edge as the latch and every pin output still comes from a flip-flop.
  always_comb begin
    p0Out_next = p0Latch_next;
    if (serialProgMode) begin
      p0Out_next[PIO_P0_TX_SER] = p0Latch_next[PIO_P0_TX_SER] & uartTxd;
      rxd_next = port0PinIn[PIO_P0_RX_SER];
    end else begin
      p0Out_next[PIO_P0_TX_NORM] = p0Latch_next[PIO_P0_TX_NORM] & uartTxd;
      rxd_next = port0PinIn[PIO_P0_RX_NORM];
    end
    // Open-drain bits only pull low; a one in the latch releases the pin, except the UART transmit bit while uartTxd is low.
    p0Oe_next = p0Drive_next | ~p0Out_next;
    p1Out_next = p1Latch_next;
    p1Oe_next = p1Dir_next;
    if (pin10InterruptSelect) begin
      p1Oe_next[PIO_P1_INT0] = 1'b0;
    end
    p2Out_next = p2Latch_next;
    p2Oe_next = ~p2Latch_next;
    if (dualClockMode) begin
      p2Oe_next[PIO_P2_OSC_IN] = 1'b0;
      p2Oe_next[PIO_P2_OSC_OUT] = 1'b0;
    end
    if (stopMode) begin
      p2Oe_next[PIO_P2_STOP] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      p0Out_reg <= PIO_P0_LATCH_RST;
      p0Oe_reg <= 8'h00;
      p1Out_reg <= PIO_P1_LATCH_RST;
      p1Oe_reg <= PIO_P1_DIR_RST;
      p2Out_reg <= PIO_P2_LATCH_RST;
      p2Oe_reg <= 3'h0;
      rxd_reg <= 1'b1;
    end else begin
      p0Out_reg <= p0Out_next;
      p0Oe_reg <= p0Oe_next;
      p1Out_reg <= p1Out_next;
      p1Oe_reg <= p1Oe_next;
      p2Out_reg <= p2Out_next;
      p2Oe_reg <= p2Oe_next;
      rxd_reg <= rxd_next;
    end
  end

  // Pins are sampled in the cycle the read is taken; no input latch exists.
  always_comb begin
    rvalid_next = busRead;
    rdata_next = rdata_reg;
    if (busRead) begin
      unique case (busAddr)
        PIO_OFF_P0_LATCH: rdata_next = p0Latch_reg;
        PIO_OFF_P0_PIN: rdata_next = port0PinIn;
        PIO_OFF_P0_DRIVE: rdata_next = p0Drive_reg;
        PIO_OFF_P1_LATCH: rdata_next = {1'b0, (p1Dir_reg & p1Latch_reg) |
                                        (~p1Dir_reg & port1PinIn)};
        PIO_OFF_P1_DIR: rdata_next = {1'b0, p1Dir_reg};
        // Upper bits are undefined to software; they read as zero here.
        PIO_OFF_P2_LATCH: rdata_next = {5'h00, p2Latch_reg};
        PIO_OFF_P2_PIN: rdata_next = {5'h00, port2PinIn};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Edges are taken from the pin level itself, so a port driving its own pin still
  // raises the interrupt; software must mask it when reconfiguring.
  pio_edge_detect #(
    .W(3)
  ) u_pio_edge_detect (
    .clk(clk),
    .reset_n(reset_n),
    .level({port2PinIn[PIO_P2_STOP], port1PinIn[1], port1PinIn[PIO_P1_INT0]}),
    .enable({1'b1, 1'b1, pin10InterruptSelect}),
    .rise(edgeRise),
    .fall(edgeFall)
  );

  assign busRdata = rdata_reg;
  assign busRdataValid = rvalid_reg;
  assign port0PinOut = p0Out_reg;
  assign port0PinOe = p0Oe_reg;
  assign port1PinOut = p1Out_reg;
  assign port1PinOe = p1Oe_reg;
  assign port2PinOut = p2Out_reg;
  assign port2PinOe = p2Oe_reg;
  assign uartRxd = rxd_reg;
  assign int0Fall = edgeFall[0];
  assign int1Rise = edgeRise[1];
  assign int1Fall = edgeFall[1];
  assign stopFall = edgeFall[2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_READ_LATENCY: assert property (busRead |=> busRdataValid)
    else $error("Read answer missing one cycle after request.");
  AST_P0_PIN_READ: assert property (busRead && busAddr == PIO_OFF_P0_PIN
    |=> busRdata == $past(port0PinIn))
    else $error("Port 0 pin read does not show pin levels of the request cycle.");
  AST_P0_LATCH_READ: assert property (busRead && busAddr == PIO_OFF_P0_LATCH
    |=> busRdata == $past(p0Latch_reg))
    else $error("Port 0 data read does not show the latch.");
  AST_P2_PIN_READ: assert property (busRead && busAddr == PIO_OFF_P2_PIN
    |=> busRdata == {5'h00, $past(port2PinIn)})
    else $error("Port 2 pin read wrong.");
  AST_P1_MIXED_READ: assert property (busRead && busAddr == PIO_OFF_P1_LATCH
    |=> busRdata[6:0] == $past((p1Dir_reg & p1Latch_reg) | (~p1Dir_reg & port1PinIn)))
    else $error("Port 1 read mixes pin and latch wrongly.");
  AST_WRITE_SECOND_STATE: assert property (busWrite && busAddr == PIO_OFF_P1_LATCH
    |=> ##1 port1PinOut == $past(busWdata[6:0], 2))
    else $error("Port 1 pins did not take written value in the second state.");
  AST_RESET_VALUES: assert property ($rose(reset_n) |-> p0Latch_reg == PIO_P0_LATCH_RST
    && p0Drive_reg == PIO_P0_DRIVE_RST && p1Dir_reg == PIO_P1_DIR_RST
    && p1Latch_reg == PIO_P1_LATCH_RST && p2Latch_reg == PIO_P2_LATCH_RST)
    else $error("Port registers not at reset values after reset.");
  AST_P1_DIRECTION: assert property (!wrPend_reg
    |=> port1PinOe[6:1] == $past(p1Dir_reg[6:1]))
    else $error("Port 1 enable does not follow direction register.");
  AST_OPEN_DRAIN: assert property (!wrPend_reg && p0Drive_reg == 8'h00
    |=> (port0PinOe & port0PinOut) == 8'h00)
    else $error("Open-drain port 0 bit drives high.");
  AST_INT_SELECT: assert property (pin10InterruptSelect |=> !port1PinOe[0])
    else $error("Port 1 bit 0 driven while used as interrupt input.");
  AST_STOP_RELEASE: assert property (stopMode |=> !port2PinOe[0])
    else $error("Stop input pin driven in stop mode.");
  AST_RESONATOR: assert property (dualClockMode |=> port2PinOe[2:1] == 2'b00)
    else $error("Resonator pins driven in dual-clock mode.");
  AST_INT1_EDGE: assert property ($changed(port1PinIn[1])
    |=> (int1Rise || int1Fall) ##1 !(int1Rise && int1Fall))
    else $error("Port 1 bit 1 edge did not pulse its interrupt.");
  AST_STOP_FALL: assert property ($fell(port2PinIn[0]) |=> stopFall)
    else $error("Port 2 bit 0 falling edge lost.");
  AST_SERIAL_RX: assert property (serialProgMode |=> uartRxd == $past(port0PinIn[2]))
    else $error("Serial mode receive not taken from port 0 bit 2.");
  AST_NORMAL_RX: assert property (!serialProgMode
    |=> uartRxd == $past(port0PinIn[PIO_P0_RX_NORM]))
    else $error("Normal mode receive not taken from port 0 bit 1.");
  AST_INT0_GATED: assert property (!pin10InterruptSelect |=> !int0Fall)
    else $error("Port 1 bit 0 edge pulsed while used as general I/O.");
  AST_INT1_QUIET: assert property (!$changed(port1PinIn[1])
    |=> !(int1Rise || int1Fall))
    else $error("Port 1 bit 1 interrupt pulsed without an edge.");
  AST_RESET_PINS: assert property ($rose(reset_n) |-> port0PinOut == PIO_P0_LATCH_RST
    && port0PinOe == 8'h00 && port1PinOe == PIO_P1_DIR_RST
    && port2PinOut == PIO_P2_LATCH_RST)
    else $error("Pin drive not at reset state after reset.");

  COV_P0_WRITE: cover property (busWrite && busAddr == PIO_OFF_P0_LATCH ##2 busRead);
  COV_INT0: cover property (pin10InterruptSelect ##1 int0Fall);
  COV_STOP: cover property (stopMode && stopFall);
endmodule
`default_nettype wire

//--- pio_pkg.sv
// Constants shared by the parallel port block: offsets, reset values and bit positions.
`default_nettype none
package pio_pkg;
  localparam int PIO_P0_W = 8;
  localparam int PIO_P1_W = 7;
  localparam int PIO_P2_W = 3;
  // Register offsets on the internal memory-mapped bus.
  localparam logic [15:0] PIO_OFF_P0_LATCH = 16'h0000;
  localparam logic [15:0] PIO_OFF_P1_LATCH = 16'h0001;
  localparam logic [15:0] PIO_OFF_P2_LATCH = 16'h0002;
  localparam logic [15:0] PIO_OFF_P1_DIR = 16'h0009;
  localparam logic [15:0] PIO_OFF_P0_DRIVE = 16'h000B;
  localparam logic [15:0] PIO_OFF_P0_PIN = 16'h000C;
  localparam logic [15:0] PIO_OFF_P2_PIN = 16'h000D;
  // Reset values.
  localparam logic [7:0] PIO_P0_LATCH_RST = 8'hFF;
  localparam logic [7:0] PIO_P0_DRIVE_RST = 8'h00;
  localparam logic [6:0] PIO_P1_LATCH_RST = 7'h00;
  localparam logic [6:0] PIO_P1_DIR_RST = 7'h00;
  localparam logic [2:0] PIO_P2_LATCH_RST = 3'h7;
  // Bit positions of shared functions.
  localparam int PIO_P0_TX_NORM = 0;
  localparam int PIO_P0_RX_NORM = 1;
  localparam int PIO_P0_RX_SER = 2;
  localparam int PIO_P0_TX_SER = 3;
  localparam int PIO_P1_INT0 = 0;
  localparam int PIO_P2_STOP = 0;
  localparam int PIO_P2_OSC_IN = 1;
  localparam int PIO_P2_OSC_OUT = 2;
endpackage
`default_nettype wire

//--- pio_edge_detect.sv
// Registered rise and fall pulse detector for a vector of synchronous pin levels.
`default_nettype none
module pio_edge_detect #(
  parameter int W = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Levels and per-bit enables.
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] enable,
  // One-cycle edge pulses.
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_reg, prev_next;
  logic [W-1:0] rise_reg, rise_next;
  logic [W-1:0] fall_reg, fall_next;

  always_comb begin
    prev_next = level;
    rise_next = enable & level & ~prev_reg;
    fall_next = enable & ~level & prev_reg;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Pins rest high on their pull-ups, so a start at zero would fake an edge after reset.
      prev_reg <= '1;
      rise_reg <= '0;
      fall_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign rise = rise_reg;
  assign fall = fall_reg;
endmodule
`default_nettype wire

//--- pio_pin_model.sv
// Pin model for the far side: resolves each pin from port driver, outside driver and pull-up.
`default_nettype none
module pio_pin_model #(
  parameter int W = 8
) (
  // Port side.
  input wire logic [W-1:0] portOut,
  input wire logic [W-1:0] portOe,
  // Outside driver.
  input wire logic [W-1:0] extVal,
  input wire logic [W-1:0] extOe,
  // Resolved level.
  output logic [W-1:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A line nobody drives rests on its pull-up, so a released pin never keeps an old value.
  always_comb begin
    for (int i = 0; i < W; i++) begin
      level[i] = portOe[i] ? portOut[i] : (extOe[i] ? extVal[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

//--- pio_ports_bench.sv
// Self-checking bench for the three parallel ports, driven through the register bus.
`default_nettype none
module pio_ports_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic busRead = 1'b0;
  logic busWrite = 1'b0;
  logic [15:0] busAddr = 16'h0000;
  logic [7:0] busWdata = 8'h00;
  logic [7:0] busRdata;
  logic busRdataValid;
  logic serialProgMode = 1'b0;
  logic dualClockMode = 1'b0;
  logic stopMode = 1'b0;
  logic pin10InterruptSelect = 1'b0;
  logic uartTxd = 1'b1;
  logic [7:0] p0Out, p0Oe, p0In;
  logic [7:0] e0Val = 8'h00;
  logic [7:0] e0Oe = 8'h00;
  logic [6:0] p1Out, p1Oe, p1In;
  logic [6:0] e1Val = 7'h00;
  logic [6:0] e1Oe = 7'h00;
  logic [2:0] p2Out, p2Oe, p2In;
  logic uartRxd, int0Fall, int1Rise, int1Fall, stopFall;
  int errorCnt = 0;
  int nCompared = 0;
  int nRise = 0;
  int nFall0 = 0;
  int nStop = 0;
  int nFall1 = 0;
  always #4 clk = ~clk;
  pio_ports u_pio_ports (.clk(clk), .reset_n(reset_n), .busAddr(busAddr), .busRead(busRead),
    .busWrite(busWrite), .busWdata(busWdata), .busRdata(busRdata),
    .busRdataValid(busRdataValid), .serialProgMode(serialProgMode),
    .dualClockMode(dualClockMode), .stopMode(stopMode),
    .pin10InterruptSelect(pin10InterruptSelect), .uartTxd(uartTxd), .port0PinIn(p0In),
    .port0PinOut(p0Out), .port0PinOe(p0Oe), .port1PinIn(p1In), .port1PinOut(p1Out),
    .port1PinOe(p1Oe), .port2PinIn(p2In), .port2PinOut(p2Out), .port2PinOe(p2Oe),
    .uartRxd(uartRxd), .int0Fall(int0Fall), .int1Rise(int1Rise), .int1Fall(int1Fall),
    .stopFall(stopFall));
  pio_pin_model #(.W(8)) u_pio_pin_model0 (.portOut(p0Out), .portOe(p0Oe), .extVal(e0Val),
    .extOe(e0Oe), .level(p0In));
  pio_pin_model #(.W(7)) u_pio_pin_model1 (.portOut(p1Out), .portOe(p1Oe), .extVal(e1Val),
    .extOe(e1Oe), .level(p1In));
  pio_pin_model #(.W(3)) u_pio_pin_model2 (.portOut(p2Out), .portOe(p2Oe), .extVal(3'h0),
    .extOe(3'h0), .level(p2In));
  // Edge pulses stand one cycle, so they are counted once at every falling clock edge.
  always @(negedge clk) begin
    if (int1Rise === 1'b1) nRise++;
    if (int1Fall === 1'b1) nFall1++;
    if (int0Fall === 1'b1) nFall0++;
    if (stopFall === 1'b1) nStop++;
  end
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    busAddr = a;
    busWdata = d;
    busWrite = 1'b1;
    @(negedge clk);
    busWrite = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    int k;
    @(negedge clk);
    busAddr = a;
    busRead = 1'b1;
    @(negedge clk);
    busRead = 1'b0;
    k = 0;
    while (busRdataValid !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    if (k == 4) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, 8'h00, 8'h01);
      wrap_up();
    end
    chk(busRdata, exp);
  endtask
  initial begin
    int k;
    settle(5);
    reset_n = 1'b1;
    chk(p0Out, 8'hFF);
    chk(p0Oe, 8'h00);
    chk({1'b0, p1Oe}, 8'h00);
    chk({5'h00, p2Out}, 8'h07);
    rd(PIO_OFF_P0_LATCH, PIO_P0_LATCH_RST);
    rd(PIO_OFF_P0_DRIVE, 8'h00);
    rd(PIO_OFF_P1_LATCH, 8'h7F);
    rd(PIO_OFF_P1_DIR, 8'h00);
    rd(PIO_OFF_P2_LATCH, 8'h07);
    $display("test reset values done");
    wr(PIO_OFF_P0_DRIVE, 8'h0F);
    wr(PIO_OFF_P0_LATCH, 8'hA5);
    e0Oe = 8'hA0;
    settle(2);
    chk(p0Oe, 8'h5F);
    chk(p0Out, 8'hA5);
    rd(PIO_OFF_P0_LATCH, 8'hA5);
    rd(PIO_OFF_P0_PIN, 8'h05);
    wr(PIO_OFF_P0_LATCH, 8'hFF);
    wr(PIO_OFF_P0_DRIVE, 8'h00);
    e0Oe = 8'hFF;
    e0Val = 8'h3C;
    settle(2);
    chk(p0Oe, 8'h00);
    fork
      rd(PIO_OFF_P0_PIN, 8'h3C);
      begin
        settle(2);
        e0Val = 8'hC3;
      end
    join
    rd(PIO_OFF_P0_PIN, 8'hC3);
    chk({7'h00, uartRxd}, 8'h01);
    serialProgMode = 1'b1;
    uartTxd = 1'b0;
    settle(2);
    chk({7'h00, uartRxd}, 8'h00);
    chk(p0Out, 8'hF7);
    serialProgMode = 1'b0;
    settle(2);
    chk(p0Out, 8'hFE);
    uartTxd = 1'b1;
    $display("test port0 done");
    e1Oe = 7'h70;
    e1Val = 7'h7F;
    wr(PIO_OFF_P1_LATCH, 8'h55);
    wr(PIO_OFF_P1_DIR, 8'h0F);
    chk({1'b0, p1Oe}, 8'h00);
    settle(1);
    chk({1'b0, p1Oe}, 8'h0F);
    chk({1'b0, p1Out}, 8'h55);
    rd(PIO_OFF_P1_LATCH, 8'h75);
    k = nRise;
    wr(PIO_OFF_P1_LATCH, 8'h57);
    settle(4);
    chk(8'(nRise - k), 8'h01);
    pin10InterruptSelect = 1'b1;
    settle(2);
    chk({1'b0, p1Oe}, 8'h0E);
    e1Oe = 7'h71;
    settle(2);
    k = nFall0;
    e1Val = 7'h7E;
    settle(4);
    chk(8'(nFall0 - k), 8'h01);
    wr(PIO_OFF_P1_DIR, 8'h0E);
    pin10InterruptSelect = 1'b0;
    e1Val = 7'h7F;
    settle(2);
    k = nFall0;
    e1Val = 7'h7E;
    settle(4);
    chk(8'(nFall0 - k), 8'h00);
    rd(PIO_OFF_P1_LATCH, 8'h76);
    k = nFall1;
    wr(PIO_OFF_P1_LATCH, 8'h55);
    settle(4);
    chk(8'(nFall1 - k), 8'h01);
    wr(16'h0004, 8'h5A);
    rd(16'h0004, 8'h00);
    rd(16'h0FE0, 8'h00);
    $display("test port1 done");
    k = nStop;
    wr(PIO_OFF_P2_LATCH, 8'h06);
    settle(4);
    chk({5'h00, p2Oe}, 8'h01);
    chk(8'(nStop - k), 8'h01);
    rd(PIO_OFF_P2_PIN, 8'h06);
    stopMode = 1'b1;
    settle(2);
    chk({5'h00, p2Oe}, 8'h00);
    stopMode = 1'b0;
    dualClockMode = 1'b1;
    wr(PIO_OFF_P2_LATCH, 8'h00);
    settle(2);
    chk({5'h00, p2Oe}, 8'h01);
    $display("test port2 done");
    wrap_up();
  end
endmodule
`default_nettype wire
